/* File: src/rrx_pkg.sv */
// rrx_pkg: shared constants, encodings and state layout for the return/reset/rotate
// execution block; assumes a 32-bit AXI4-Lite register bus and one core clock
package rrx_pkg;
	// widths and depths of the core state
	localparam int PC_W        = 15;
	localparam int STACK_MAX   = 16;
	localparam int SP_W        = 4;
	localparam int FILE_WORDS  = 128;
	localparam int FADDR_W     = 7;

	// register byte addresses
	localparam logic [7:0] A_INSTR   = 8'h00; // write issues an instruction word
	localparam logic [7:0] A_STATUS  = 8'h04; // read-only core state
	localparam logic [7:0] A_WREG    = 8'h08; // working accumulator
	localparam logic [7:0] A_OPTION  = 8'h0c; // option configuration register
	localparam logic [7:0] A_PUSH    = 8'h10; // write pushes a return address
	localparam logic [7:0] A_FSEL    = 8'h14; // data register select
	localparam logic [7:0] A_FDATA   = 8'h18; // selected data register
	localparam logic [7:0] A_IRQCTL  = 8'h1c; // irq_control_register
	localparam logic [7:0] A_STKTOP  = 8'h20; // stack_top_value, read-only
	localparam logic [7:0] A_PWRCTL  = 8'h24; // power_control_register, read-only

	// field positions
	localparam int OP_HI        = 15;
	localparam int OP_LO        = 12;
	localparam int ROT_DEST_BIT = 7;
	localparam int IRQ_EN_BIT   = 7;
	localparam int RST_IND_BIT  = 0;
	localparam int ST_BUSY      = 0;
	localparam int ST_CARRY     = 1;
	localparam int ST_RST_IND   = 2;
	localparam int ST_IRQ_EN    = 3;
	localparam int ST_SP_LO     = 4;
	localparam int ST_PC_LO     = 16;

	// reset values
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic       IND_RST    = 1'b1;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// instruction classes in bits 15:12 of the issued word
	typedef enum logic [3:0] {
		OP_NOP    = 4'h0,
		OP_OPTION = 4'h1,
		OP_RESET  = 4'h2,
		OP_RETURN = 4'h3,
		OP_IRQRET = 4'h4, // interrupt_return_op
		OP_LITRET = 4'h5, // literal_return_op, literal in bits 7:0
		OP_ROTL   = 4'h6  // rotate_left_carry_op, dest bit 7, register 6:0
	} rrx_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_RET2 = 2'b10
	} rrx_st_e;

	// AXI4-Lite slave side state
	typedef struct packed {
		logic        aw_hold;
		logic [7:0]  aw_addr;
		logic        w_hold;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rrx_bus_s;

	// processor core state touched by this instruction group
	typedef struct packed {
		rrx_st_e                            st;
		logic [15:0]                        instr;
		logic [7:0]                         w;
		logic [7:0]                         option;
		logic                               carry;
		logic [7:0]                         irqctl;
		logic                               rst_ind;
		logic [PC_W-1:0]                    pc;
		logic [SP_W-1:0]                    sp;
		logic [STACK_MAX-1:0][PC_W-1:0]     stack;
		logic [FILE_WORDS-1:0][7:0]         file;
		logic [FADDR_W-1:0]                 fsel;
		logic                               rst_req;
	} rrx_core_s;

	typedef struct packed {
		rrx_bus_s  bus;
		rrx_core_s core;
	} rrx_state_s;
endpackage

/* File: src/rrx_exec.sv */
// rrx_exec: executes option-load, software reset, the three returns and rotate-left
// assumes an AXI4-Lite master issues instruction words and inspects core state
//
// Operation
// [RULE1] option-load copies accumulator into option register
// [RULE2] software reset clears the reset-instruction indicator
// [RULE3] software reset forces a full device reset
// [RULE4] interrupt return pops stack into program counter
// [RULE5] interrupt return sets global interrupt enable bit
// [RULE6] returns take one word, two cycles
// [RULE7] literal return loads 8-bit literal into accumulator
// [RULE8] literal return also pops stack into counter
// [RULE9] plain return pops stack, interrupt enable untouched
// [RULE10] rotate-left shifts register left through carry
// [RULE11] destination bit 0 to accumulator, 1 to register
// [RULE12] old carry enters bit 0, old bit 7 becomes carry
`timescale 1ns/10ps
module rrx_exec #(
	parameter int STACK_DEPTH = 16
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output logic             DEV_RESET_REQ
);
	// the stack pointer wraps modulo 16, so only a depth equal to the package STACK_MAX is served
	if (STACK_DEPTH != rrx_pkg::STACK_MAX) begin : g_depth_check
		$error("STACK_DEPTH must equal the package stack size");
	end

	rrx_pkg::rrx_state_s q;
	rrx_pkg::rrx_state_s d;
	rrx_pkg::rrx_core_s  core_rst;
	rrx_pkg::rrx_bus_s   bus_rst;

	// decoded view of the instruction being executed
	rrx_pkg::rrx_op_e             op;
	logic                         exec;
	logic [rrx_pkg::FADDR_W-1:0]  rot_addr;
	logic [7:0]                   rot_src;
	logic [rrx_pkg::PC_W-1:0]     stk_top;
	logic [rrx_pkg::SP_W-1:0]     sp_dec;

	assign op       = rrx_pkg::rrx_op_e'(q.core.instr[rrx_pkg::OP_HI:rrx_pkg::OP_LO]);
	assign exec     = q.core.st == rrx_pkg::ST_EXEC;
	assign rot_addr = q.core.instr[rrx_pkg::FADDR_W-1:0];
	assign rot_src  = q.core.file[rot_addr];
	assign sp_dec   = q.core.sp - 1'b1;
	assign stk_top  = q.core.stack[sp_dec];

	// reset image of the core, shared by the pin reset and the software reset
	always_comb begin
		core_rst        = '0;
		core_rst.st     = rrx_pkg::ST_IDLE;
		core_rst.option = rrx_pkg::OPTION_RST;
		core_rst.rst_ind = rrx_pkg::IND_RST;
		bus_rst         = '0;
		bus_rst.awready = 1'b1;
		bus_rst.wready  = 1'b1;
		bus_rst.arready = 1'b1;
	end

	// byte-lane merge for bus writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// next-state logic: bus slave first, then instruction execution
	always_comb begin
		logic [31:0] wv;
		logic [31:0] rv;
		logic        err;
		wv = '0;
		rv = '0;
		err = 1'b0;
		d = q;
		d.core.rst_req = 1'b0;

		// write channel capture, address and data in either order
		if (S_AXI_AWVALID && q.bus.awready) begin
			d.bus.aw_hold = 1'b1;
			d.bus.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && q.bus.wready) begin
			d.bus.w_hold = 1'b1;
			d.bus.w_data = S_AXI_WDATA;
			d.bus.w_strb = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			d.bus.bvalid = 1'b0;
		end

		// perform the write once both halves are held; the core refuses while busy
		if (q.bus.aw_hold && q.bus.w_hold && !q.bus.bvalid) begin
			d.bus.aw_hold = 1'b0;
			d.bus.w_hold  = 1'b0;
			d.bus.bvalid  = 1'b1;
			err = q.core.st != rrx_pkg::ST_IDLE;
			if (!err) begin
				if (q.bus.aw_addr == rrx_pkg::A_INSTR) begin
					wv = merge({16'h0000, q.core.instr}, q.bus.w_data, q.bus.w_strb);
					d.core.instr = wv[15:0];
					d.core.st = rrx_pkg::ST_EXEC;
				end else if (q.bus.aw_addr == rrx_pkg::A_WREG) begin
					wv = merge({24'h000000, q.core.w}, q.bus.w_data, q.bus.w_strb);
					d.core.w = wv[7:0];
				end else if (q.bus.aw_addr == rrx_pkg::A_PUSH) begin
					d.core.stack[q.core.sp] = q.bus.w_data[rrx_pkg::PC_W-1:0];
					d.core.sp = q.core.sp + 1'b1;
				end else if (q.bus.aw_addr == rrx_pkg::A_FSEL) begin
					wv = merge({25'h0000000, q.core.fsel}, q.bus.w_data, q.bus.w_strb);
					d.core.fsel = wv[rrx_pkg::FADDR_W-1:0];
				end else if (q.bus.aw_addr == rrx_pkg::A_FDATA) begin
					wv = merge({24'h000000, q.core.file[q.core.fsel]}, q.bus.w_data,
						q.bus.w_strb);
					d.core.file[q.core.fsel] = wv[7:0];
				end else if (q.bus.aw_addr == rrx_pkg::A_IRQCTL) begin
					wv = merge({24'h000000, q.core.irqctl}, q.bus.w_data, q.bus.w_strb);
					d.core.irqctl = wv[7:0];
				end else begin
					err = 1'b1; // unmapped or read-only offset
				end
			end
			d.bus.bresp = err ? rrx_pkg::RESP_SLVERR : rrx_pkg::RESP_OKAY;
		end
		// one write in flight: ready drops while a half is held or a response waits
		d.bus.awready = !d.bus.aw_hold && !d.bus.bvalid;
		d.bus.wready  = !d.bus.w_hold && !d.bus.bvalid;

		// read channel: one cycle from address to data
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			d.bus.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && q.bus.arready) begin
			d.bus.rvalid = 1'b1;
			d.bus.rresp  = rrx_pkg::RESP_OKAY;
			if (S_AXI_ARADDR == rrx_pkg::A_INSTR) begin
				rv[15:0] = q.core.instr;
			end else if (S_AXI_ARADDR == rrx_pkg::A_STATUS) begin
				rv[rrx_pkg::ST_BUSY]  = q.core.st != rrx_pkg::ST_IDLE;
				rv[rrx_pkg::ST_CARRY] = q.core.carry;
				rv[rrx_pkg::ST_RST_IND] = q.core.rst_ind;
				rv[rrx_pkg::ST_IRQ_EN]  = q.core.irqctl[rrx_pkg::IRQ_EN_BIT];
				rv[rrx_pkg::ST_SP_LO +: rrx_pkg::SP_W] = q.core.sp;
				rv[rrx_pkg::ST_PC_LO +: rrx_pkg::PC_W] = q.core.pc;
			end else if (S_AXI_ARADDR == rrx_pkg::A_WREG) begin
				rv[7:0] = q.core.w;
			end else if (S_AXI_ARADDR == rrx_pkg::A_OPTION) begin
				rv[7:0] = q.core.option;
			end else if (S_AXI_ARADDR == rrx_pkg::A_FSEL) begin
				rv[rrx_pkg::FADDR_W-1:0] = q.core.fsel;
			end else if (S_AXI_ARADDR == rrx_pkg::A_FDATA) begin
				rv[7:0] = q.core.file[q.core.fsel];
			end else if (S_AXI_ARADDR == rrx_pkg::A_IRQCTL) begin
				rv[7:0] = q.core.irqctl;
			end else if (S_AXI_ARADDR == rrx_pkg::A_STKTOP) begin
				rv[rrx_pkg::PC_W-1:0] = stk_top;
			end else if (S_AXI_ARADDR == rrx_pkg::A_PWRCTL) begin
				rv[rrx_pkg::RST_IND_BIT] = q.core.rst_ind;
			end else begin
				d.bus.rresp = rrx_pkg::RESP_SLVERR;
			end
			d.bus.rdata = rv;
		end
		d.bus.arready = !d.bus.rvalid;

		// instruction execution; returns spend a second cycle in ST_RET2
		case (q.core.st)
			rrx_pkg::ST_EXEC: begin
				d.core.st = rrx_pkg::ST_IDLE;
				case (op)
					rrx_pkg::OP_OPTION: begin
						d.core.option = q.core.w; // RULE1
					end
					rrx_pkg::OP_RESET: begin
						d.core = core_rst; // RULE3
						d.core.rst_ind = 1'b0; // RULE2
						d.core.rst_req = 1'b1; // RULE3
					end
					rrx_pkg::OP_RETURN: begin
						d.core.pc = stk_top; // RULE9
						d.core.sp = sp_dec; // RULE9
						d.core.st = rrx_pkg::ST_RET2; // RULE6
					end
					rrx_pkg::OP_IRQRET: begin
						d.core.pc = stk_top; // RULE4
						d.core.sp = sp_dec; // RULE4
						d.core.irqctl[rrx_pkg::IRQ_EN_BIT] = 1'b1; // RULE5
						d.core.st = rrx_pkg::ST_RET2; // RULE6
					end
					rrx_pkg::OP_LITRET: begin
						d.core.w = q.core.instr[7:0]; // RULE7
						d.core.pc = stk_top; // RULE8
						d.core.sp = sp_dec; // RULE8
						d.core.st = rrx_pkg::ST_RET2; // RULE6
					end
					rrx_pkg::OP_ROTL: begin
						d.core.carry = rot_src[7]; // RULE12
						if (q.core.instr[rrx_pkg::ROT_DEST_BIT]) begin
							d.core.file[rot_addr] = {rot_src[6:0], q.core.carry}; // RULE11
						end else begin
							d.core.w = {rot_src[6:0], q.core.carry}; // RULE10
						end
					end
					default: begin
						d.core.st = rrx_pkg::ST_IDLE; // other codes act as no operation
					end
				endcase
			end
			rrx_pkg::ST_RET2: begin
				d.core.st = rrx_pkg::ST_IDLE; // RULE6
			end
			default: begin
				d.core.st = d.core.st;
			end
		endcase
	end

	// single state register; synchronous active-low reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			q.core <= core_rst;
			q.bus  <= bus_rst;
		end else begin
			q <= d;
		end
	end

	// every output taken straight from the state register
	assign S_AXI_AWREADY = q.bus.awready;
	assign S_AXI_WREADY  = q.bus.wready;
	assign S_AXI_BVALID  = q.bus.bvalid;
	assign S_AXI_BRESP   = q.bus.bresp;
	assign S_AXI_ARREADY = q.bus.arready;
	assign S_AXI_RVALID  = q.bus.rvalid;
	assign S_AXI_RDATA   = q.bus.rdata;
	assign S_AXI_RRESP   = q.bus.rresp;
	assign DEV_RESET_REQ = q.core.rst_req;

	// checks tying each instruction to its effect one cycle later
	property p_option_load;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_OPTION |=> q.core.option == $past(q.core.w)
			&& q.core.carry == $past(q.core.carry);
	endproperty
	a_option_load: assert property (p_option_load) else $error("option load wrong"); // RULE1

	property p_reset_ind;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_RESET |=> !q.core.rst_ind;
	endproperty
	a_reset_ind: assert property (p_reset_ind) else $error("indicator not cleared"); // RULE2

	property p_reset_full;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_RESET |=> DEV_RESET_REQ && q.core.pc == '0
			&& q.core.sp == '0 && q.core.option == rrx_pkg::OPTION_RST ##1 !DEV_RESET_REQ;
	endproperty
	a_reset_full: assert property (p_reset_full) else $error("software reset incomplete"); // RULE3

	property p_irq_ret_pc;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_IRQRET |=> q.core.pc == $past(stk_top)
			&& q.core.sp == $past(sp_dec);
	endproperty
	a_irq_ret_pc: assert property (p_irq_ret_pc) else $error("irq return pop wrong"); // RULE4

	property p_irq_ret_en;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_IRQRET |=> q.core.irqctl[rrx_pkg::IRQ_EN_BIT];
	endproperty
	a_irq_ret_en: assert property (p_irq_ret_en) else $error("irq enable not set"); // RULE5

	property p_ret_cycles;
		@(posedge CLK) disable iff (!RST_N)
		exec && (op == rrx_pkg::OP_RETURN || op == rrx_pkg::OP_IRQRET
			|| op == rrx_pkg::OP_LITRET)
		|=> q.core.st == rrx_pkg::ST_RET2 ##1 q.core.st == rrx_pkg::ST_IDLE;
	endproperty
	a_ret_cycles: assert property (p_ret_cycles) else $error("return not two cycles"); // RULE6

	property p_lit_ret_w;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_LITRET |=> q.core.w == $past(q.core.instr[7:0]);
	endproperty
	a_lit_ret_w: assert property (p_lit_ret_w) else $error("literal not loaded"); // RULE7

	property p_lit_ret_pc;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_LITRET |=> q.core.pc == $past(stk_top)
			&& q.core.sp == $past(sp_dec);
	endproperty
	a_lit_ret_pc: assert property (p_lit_ret_pc) else $error("literal return pop wrong"); // RULE8

	property p_return_en;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_RETURN |=> q.core.pc == $past(stk_top)
			&& $stable(q.core.irqctl);
	endproperty
	a_return_en: assert property (p_return_en) else $error("plain return wrong"); // RULE9

	property p_rot_w;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_ROTL && !q.core.instr[rrx_pkg::ROT_DEST_BIT]
		|=> q.core.w == {$past(rot_src[6:0]), $past(q.core.carry)};
	endproperty
	a_rot_w: assert property (p_rot_w) else $error("rotate to accumulator wrong"); // RULE10

	property p_rot_f;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_ROTL && q.core.instr[rrx_pkg::ROT_DEST_BIT]
		|=> rot_src == {$past(rot_src[6:0]), $past(q.core.carry)} && $stable(q.core.w);
	endproperty
	a_rot_f: assert property (p_rot_f) else $error("rotate to register wrong"); // RULE11

	property p_rot_carry;
		@(posedge CLK) disable iff (!RST_N)
		exec && op == rrx_pkg::OP_ROTL |=> q.core.carry == $past(rot_src[7]);
	endproperty
	a_rot_carry: assert property (p_rot_carry) else $error("carry not from bit 7"); // RULE12
endmodule

/* File: testbench/rrx_fetch_model.sv */
// rrx_fetch_model: fetch/decode side that issues instruction words and probes core state
// assumes the execution block answers as an AXI4-Lite slave on the same clock
`timescale 1ns/10ps
module rrx_fetch_model (
	input  wire logic        clk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// idle bus at time zero
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	// write: both halves offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			// released payload is inverted so nothing leans on a stale value
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
	endtask

	// read: address held until taken, data taken at the edge rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
	endtask
endmodule

/* File: testbench/return_reset_rotate_exec_tb.sv */
// return_reset_rotate_exec_tb: self-checking bench for the return/reset/rotate block
// assumes the fetch model drives the register bus and reset is synchronous
`timescale 1ns/10ps
module return_reset_rotate_exec_tb;
	logic        clk;
	logic        rst_n;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, dev_rst;
	logic [31:0] rv;
	logic [1:0]  resp;
	logic [8:0]  x;
	logic [7:0]  v, wv;
	logic [6:0]  r;
	logic [14:0] a1, a2;
	logic        c;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          pulses = 0;
	int          cycles = 0;
	int          p0;

	rrx_exec #(.STACK_DEPTH(16)) i_dut (.CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DEV_RESET_REQ(dev_rst));

	rrx_fetch_model i_fm (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// reset pulses counted here; the hang limit sits well above the expected run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (dev_rst === 1'b1) pulses <= pulses + 1;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// nine-bit rotation: {new carry, result}
	function automatic logic [8:0] rot(input logic [7:0] val, input logic cin);
		return {val, cin};
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
		i_fm.rd(a, rv, resp);
		chk(what, e, rv);
	endtask

	// issue one instruction and poll until the core is no longer busy
	task automatic issue(input logic [15:0] ins);
		i_fm.wr(rrx_pkg::A_INSTR, {16'h0, ins}, resp);
		chk("issue resp", {30'h0, rrx_pkg::RESP_OKAY}, {30'h0, resp});
		repeat (20) begin
			i_fm.rd(rrx_pkg::A_STATUS, rv, resp);
			if (rv[rrx_pkg::ST_BUSY] === 1'b0) break;
		end
		chk("issue done", 32'h0, {31'h0, rv[rrx_pkg::ST_BUSY]});
	endtask

	initial begin
		rst_n = 1'b0;
		void'($urandom(32'h43efb003));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rdc(rrx_pkg::A_OPTION, 32'hff, "option reset");
		rdc(rrx_pkg::A_PWRCTL, 32'h1, "indicator reset");
		// rotate: both destinations, corner values first, carry tracked here
		c = 1'b0;
		for (int i = 0; i < 8; i++) begin
			r = 7'($urandom);
			v = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
			wv = 8'($urandom);
			i_fm.wr(rrx_pkg::A_FSEL, {25'h0, r}, resp);
			i_fm.wr(rrx_pkg::A_FDATA, {24'h0, v}, resp);
			i_fm.wr(rrx_pkg::A_WREG, {24'h0, wv}, resp);
			issue({rrx_pkg::OP_ROTL, 4'h0, i[0], r});
			x = rot(v, c);
			rdc(rrx_pkg::A_WREG, {24'h0, i[0] ? wv : x[7:0]}, "rotate acc");
			rdc(rrx_pkg::A_FDATA, {24'h0, i[0] ? x[7:0] : v}, "rotate reg");
			i_fm.rd(rrx_pkg::A_STATUS, rv, resp);
			chk("rotate carry", {31'h0, x[8]}, {31'h0, rv[rrx_pkg::ST_CARRY]});
			c = x[8];
		end
		$display("test rotate done");
		// option load, carry must survive
		v = 8'($urandom) & 8'h7f;
		i_fm.wr(rrx_pkg::A_WREG, {24'h0, v | 8'h01}, resp);
		issue({rrx_pkg::OP_OPTION, 12'h000});
		rdc(rrx_pkg::A_OPTION, {24'h0, v | 8'h01}, "option load");
		i_fm.rd(rrx_pkg::A_STATUS, rv, resp);
		chk("option carry", {31'h0, c}, {31'h0, rv[rrx_pkg::ST_CARRY]});
		$display("test option done");
		// returns: plain keeps enable clear, interrupt return sets it
		a1 = 15'($urandom);
		a2 = 15'($urandom);
		i_fm.wr(rrx_pkg::A_IRQCTL, 32'h0, resp);
		i_fm.wr(rrx_pkg::A_PUSH, {17'h0, a1}, resp);
		i_fm.wr(rrx_pkg::A_PUSH, {17'h0, a2}, resp);
		issue({rrx_pkg::OP_RETURN, 12'h000});
		i_fm.rd(rrx_pkg::A_STATUS, rv, resp);
		chk("return pc", {17'h0, a2}, {17'h0, rv[30:16]});
		chk("return sp", 32'h1, {28'h0, rv[7:4]});
		rdc(rrx_pkg::A_IRQCTL, 32'h0, "return gie");
		issue({rrx_pkg::OP_IRQRET, 12'h000});
		i_fm.rd(rrx_pkg::A_STATUS, rv, resp);
		chk("irq return pc", {17'h0, a1}, {17'h0, rv[30:16]});
		chk("irq return sp", 32'h0, {28'h0, rv[7:4]});
		rdc(rrx_pkg::A_IRQCTL, 32'h80, "irq return gie");
		// literal return with boundary then random literal
		for (int i = 0; i < 2; i++) begin
			a1 = 15'($urandom);
			v = i ? 8'($urandom) : 8'hff;
			i_fm.wr(rrx_pkg::A_PUSH, {17'h0, a1}, resp);
			issue({rrx_pkg::OP_LITRET, 4'h0, v});
			rdc(rrx_pkg::A_WREG, {24'h0, v}, "literal w");
			i_fm.rd(rrx_pkg::A_STATUS, rv, resp);
			chk("literal pc", {17'h0, a1}, {17'h0, rv[30:16]});
		end
		$display("test returns done");
		// refused accesses
		i_fm.wr(8'h3c, 32'h1, resp);
		chk("unmapped write", {30'h0, rrx_pkg::RESP_SLVERR}, {30'h0, resp});
		i_fm.wr(rrx_pkg::A_OPTION, 32'h5, resp);
		chk("ro write", {30'h0, rrx_pkg::RESP_SLVERR}, {30'h0, resp});
		rdc(8'h3c, 32'h0, "unmapped read");
		chk("unmapped read resp", {30'h0, rrx_pkg::RESP_SLVERR}, {30'h0, resp});
		$display("test refusals done");
		// software reset: one pulse, state back to reset values, indicator cleared
		p0 = pulses;
		issue({rrx_pkg::OP_RESET, 12'h000});
		chk("reset pulse", 32'h1, 32'(pulses - p0));
		rdc(rrx_pkg::A_PWRCTL, 32'h0, "indicator cleared");
		rdc(rrx_pkg::A_OPTION, 32'hff, "option after reset");
		rdc(rrx_pkg::A_WREG, 32'h0, "w after reset");
		rdc(rrx_pkg::A_IRQCTL, 32'h0, "irq after reset");
		$display("test software reset done");
		tally_and_finish();
	end
endmodule
